// ==== inc/acc_regs.svh ====
// register offsets, field positions, reset values and widths
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// special-function address of the conversion control register
`define ACC_CTRL_ADDR          8'hd8
// bit-addressable space: bit address = base + bit index
`define ACC_CTRL_BIT_BASE      8'hd8
`define ACC_CTRL_RESET         8'h00

// field positions
`define ACC_FLAG_BIT           7
`define ACC_DMA_BIT            6
`define ACC_CONT_BIT           5
`define ACC_SINGLE_BIT         4
`define ACC_CHAN_HI            3
`define ACC_CHAN_LO            0

// widths
`define ACC_CHAN_W             4
`define ACC_RESULT_W           12

`endif

// ==== inc/acc_pkg.sv ====
// types shared by the conversion-control design
package acc_pkg;

	typedef logic [7:0]  acc_byte_t;
	typedef logic [3:0]  acc_chan_t;
	typedef logic [11:0] acc_result_t;

	// conversion sequencer states
	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_START,
		ACC_BUSY
	} acc_state_t;

	// what started the conversion in flight
	typedef enum logic [1:0] {
		ACC_KIND_SINGLE,
		ACC_KIND_CONT,
		ACC_KIND_TRIG,
		ACC_KIND_DMA
	} acc_kind_t;

endpackage

// ==== core/acc_trigger.sv ====
// hardware conversion trigger: timer overflow and external convert pin
`timescale 1ns/1ps
`default_nettype none

module acc_trigger (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// trigger enables from the companion control register
	input  wire logic timer_trigger_enable,
	input  wire logic external_trigger_enable,
	// trigger sources
	input  wire logic timer2_overflow,
	input  wire logic external_convert_pin_b,
	// combined request, one cycle
	output logic      trigger_pulse
);
	logic pin_prev_reg;
	logic pin_prev_next;
	logic trig_reg;
	logic trig_next;

	always_comb begin
		pin_prev_next = external_convert_pin_b;
		trig_next = 1'b0;
		if (timer_trigger_enable && timer2_overflow) begin
			trig_next = 1'b1; // see R13
		end
		// falling edge only: a long low pulse gives one conversion
		if (external_trigger_enable && pin_prev_reg &&
		    !external_convert_pin_b) begin
			trig_next = 1'b1; // see R14
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_prev_reg <= 1'b1;
			trig_reg     <= 1'b0;
		end else begin
			pin_prev_reg <= pin_prev_next;
			trig_reg     <= trig_next;
		end
	end

	assign trigger_pulse = trig_reg;

endmodule

`default_nettype wire

// ==== core/acc_ctrl.sv ====
// conversion control register and conversion sequencer of the adc
// What this block does
// R1 - set done flag at end of single conversion or DMA block
// R2 - clear done flag when the core vectors to the adc interrupt
// R3 - without vectoring, software clears the done flag by writing zero
// R4 - writing one to bit 6 enables DMA mode; hardware clears it at end
// R5 - address latch strobe is held off while DMA bit is set
// R6 - continuous bit restarts a conversion each time one completes
// R7 - continuous conversions reuse current register settings, no reconfig
// R8 - writing one to single bit starts exactly one conversion
// R9 - single bit clears itself when its conversion completes
// R10 - outside DMA, channel is bits 3..0 sampled at conversion start
// R11 - in DMA mode, channel comes from the stored channel identifier
// R12 - register at D8H, resets 00H, every bit writable singly
// R13 - timer 2 overflow starts a conversion when timer trigger enabled
// R14 - falling edge on external convert pin starts conversion when enabled
// R15 - channel bits written to top four bits of result high byte
// R16 - hardware flag set wins over same-cycle software clear
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"

module acc_ctrl (
	// clock and reset
	input  wire logic            clk,
	input  wire logic            rst_b,
	// special-function register byte access
	input  wire logic [7:0]      sfr_addr,
	input  wire logic            sfr_wr,
	input  wire logic            sfr_rd,
	input  wire acc_pkg::acc_byte_t sfr_wdata,
	output acc_pkg::acc_byte_t   sfr_rdata,
	// bit-addressable access
	input  wire logic [7:0]      bit_addr,
	input  wire logic            bit_wr,
	input  wire logic            bit_wdata,
	// interrupt vector acknowledge from the core
	input  wire logic            int_ack,
	// companion register trigger enables and trigger sources
	input  wire logic            timer_trigger_enable,
	input  wire logic            external_trigger_enable,
	input  wire logic            timer2_overflow,
	input  wire logic            external_convert_pin_b,
	// dma engine
	input  wire acc_pkg::acc_chan_t dma_chan_id,
	input  wire logic            dma_block_done,
	output logic                 dma_active,
	// address latch strobe
	input  wire logic            ale_in,
	output logic                 ale_out,
	// analog converter
	output logic                 conv_start,
	output acc_pkg::acc_chan_t   conv_channel,
	input  wire logic            conv_done,
	input  wire acc_pkg::acc_result_t conv_result,
	// result bytes
	output acc_pkg::acc_byte_t   result_high_byte,
	output acc_pkg::acc_byte_t   result_low_byte,
	output logic                 conversion_done_flag
);
	import acc_pkg::*;

	// ==========================================================
	// helpers
	// ==========================================================

	// does a bit access hit a given field of the control register
	function automatic logic bit_hit(input logic [7:0] addr,
	                                 input int unsigned idx);
		logic [7:0] target;
		target = `ACC_CTRL_BIT_BASE + idx[7:0];
		bit_hit = (addr == target);
	endfunction

	// ==========================================================
	// state
	// ==========================================================

	acc_byte_t  ctrl_reg;
	acc_byte_t  ctrl_next;
	acc_byte_t  rdata_reg;
	acc_byte_t  rdata_next;
	acc_state_t state_reg;
	acc_state_t state_next;
	acc_kind_t  kind_reg;
	acc_kind_t  kind_next;
	acc_chan_t  chan_reg;
	acc_chan_t  chan_next;
	logic       start_reg;
	logic       start_next;
	acc_byte_t  res_hi_reg;
	acc_byte_t  res_hi_next;
	acc_byte_t  res_lo_reg;
	acc_byte_t  res_lo_next;
	logic       ale_reg;
	logic       ale_next;

	logic       trig_pulse;
	acc_byte_t  sw_val;
	logic       flag_set;
	logic       single_clear;
	logic       dma_clear;
	logic       wr_hit;

	// ==========================================================
	// hardware trigger sources
	// ==========================================================

	acc_trigger u_trigger (
		.clk                     (clk),
		.rst_b                   (rst_b),
		.timer_trigger_enable    (timer_trigger_enable),
		.external_trigger_enable (external_trigger_enable),
		.timer2_overflow         (timer2_overflow),
		.external_convert_pin_b  (external_convert_pin_b),
		.trigger_pulse           (trig_pulse)
	);

	// ==========================================================
	// conversion sequencer
	// ==========================================================

	always_comb begin
		state_next   = state_reg;
		kind_next    = kind_reg;
		chan_next    = chan_reg;
		start_next   = 1'b0;
		flag_set     = 1'b0;
		single_clear = 1'b0;
		dma_clear    = 1'b0;
		res_hi_next  = res_hi_reg;
		res_lo_next  = res_lo_reg;
		case (state_reg)
		ACC_IDLE: begin
			// dma takes precedence, then software, then hardware triggers
			if (ctrl_reg[`ACC_DMA_BIT]) begin
				kind_next  = ACC_KIND_DMA;
				chan_next  = dma_chan_id; // see R11
				start_next = 1'b1;
				state_next = ACC_START;
			end else if (ctrl_reg[`ACC_SINGLE_BIT]) begin
				kind_next  = ACC_KIND_SINGLE; // see R8
				chan_next  = ctrl_reg[`ACC_CHAN_HI:`ACC_CHAN_LO]; // see R10
				start_next = 1'b1;
				state_next = ACC_START;
			end else if (ctrl_reg[`ACC_CONT_BIT]) begin
				// settings are sampled live, nothing to reload; see R7
				kind_next  = ACC_KIND_CONT;
				chan_next  = ctrl_reg[`ACC_CHAN_HI:`ACC_CHAN_LO]; // see R10
				start_next = 1'b1;
				state_next = ACC_START;
			end else if (trig_pulse) begin
				kind_next  = ACC_KIND_TRIG;
				chan_next  = ctrl_reg[`ACC_CHAN_HI:`ACC_CHAN_LO];
				start_next = 1'b1;
				state_next = ACC_START;
			end
		end
		ACC_START: begin
			// one cycle so conv_start and conv_channel go out together
			state_next = ACC_BUSY;
		end
		ACC_BUSY: begin
			if (kind_reg == ACC_KIND_DMA && dma_block_done) begin
				dma_clear  = 1'b1; // see R4
				flag_set   = 1'b1; // see R1
				state_next = ACC_IDLE;
			end else if (conv_done) begin
				// channel tags the result so each sample names itself
				res_hi_next = {chan_reg, conv_result[11:8]}; // see R15
				res_lo_next = conv_result[7:0];
				if (kind_reg == ACC_KIND_DMA) begin
					// next dma sample, flag only at block end
					if (ctrl_reg[`ACC_DMA_BIT]) begin
						chan_next  = dma_chan_id; // see R11
						start_next = 1'b1;
						state_next = ACC_START;
					end else begin
						state_next = ACC_IDLE;
					end
				end else begin
					flag_set = 1'b1; // see R1
					if (kind_reg == ACC_KIND_SINGLE) begin
						single_clear = 1'b1; // see R9
					end
					// back-to-back restart while continuous; see R6
					if (ctrl_reg[`ACC_CONT_BIT] &&
					    !ctrl_reg[`ACC_DMA_BIT]) begin
						kind_next  = ACC_KIND_CONT;
						chan_next  = ctrl_reg[`ACC_CHAN_HI:`ACC_CHAN_LO];
						start_next = 1'b1;
						state_next = ACC_START;
					end else begin
						state_next = ACC_IDLE;
					end
				end
			end
		end
		default: begin
			state_next = ACC_IDLE;
		end
		endcase
	end

	// ==========================================================
	// control register
	// ==========================================================

	always_comb begin
		sw_val = ctrl_reg;
		wr_hit = sfr_wr && (sfr_addr == `ACC_CTRL_ADDR);
		if (wr_hit) begin
			sw_val = sfr_wdata; // see R12
		end else if (bit_wr) begin
			for (int unsigned i = 0; i < 8; i++) begin
				if (bit_hit(bit_addr, i)) begin
					sw_val[i] = bit_wdata; // see R12
				end
			end
		end
		ctrl_next = sw_val;
		// software zero clears the flag; see R3
		// vector acknowledge clears it
		if (int_ack) begin
			ctrl_next[`ACC_FLAG_BIT] = 1'b0; // see R2
		end
		// a completion in the same cycle outlives any clear; see R16
		if (flag_set) begin
			ctrl_next[`ACC_FLAG_BIT] = 1'b1;
		end
		// a write of one re-arms only if the single bit was already zero; otherwise it is cleared
		if (single_clear && !(sw_val[`ACC_SINGLE_BIT] &&
		    !ctrl_reg[`ACC_SINGLE_BIT])) begin
			ctrl_next[`ACC_SINGLE_BIT] = 1'b0; // see R9
		end
		if (dma_clear) begin
			ctrl_next[`ACC_DMA_BIT] = 1'b0; // see R4
		end
	end

	// ==========================================================
	// read port and strobe gating
	// ==========================================================

	always_comb begin
		rdata_next = 8'h00;
		if (sfr_rd && sfr_addr == `ACC_CTRL_ADDR) begin
			rdata_next = ctrl_reg;
		end
		// strobe held low for the whole dma window
		ale_next = ale_in && !ctrl_next[`ACC_DMA_BIT]; // see R5
	end

	// ==========================================================
	// registers
	// ==========================================================

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg   <= `ACC_CTRL_RESET; // see R12
			rdata_reg  <= 8'h00;
			state_reg  <= ACC_IDLE;
			kind_reg   <= ACC_KIND_SINGLE;
			chan_reg   <= 4'h0;
			start_reg  <= 1'b0;
			res_hi_reg <= 8'h00;
			res_lo_reg <= 8'h00;
			ale_reg    <= 1'b0;
		end else begin
			ctrl_reg   <= ctrl_next;
			rdata_reg  <= rdata_next;
			state_reg  <= state_next;
			kind_reg   <= kind_next;
			chan_reg   <= chan_next;
			start_reg  <= start_next;
			res_hi_reg <= res_hi_next;
			res_lo_reg <= res_lo_next;
			ale_reg    <= ale_next;
		end
	end

	assign sfr_rdata            = rdata_reg;
	assign conv_start           = start_reg;
	assign conv_channel         = chan_reg;
	assign result_high_byte     = res_hi_reg;
	assign result_low_byte      = res_lo_reg;
	assign conversion_done_flag = ctrl_reg[`ACC_FLAG_BIT];
	assign dma_active           = ctrl_reg[`ACC_DMA_BIT];
	assign ale_out              = ale_reg;

endmodule

`default_nettype wire

// ==== tb/acc_ctrl_properties.sv ====
// concurrent checks on the conversion control ports
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_properties (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst_b,
	// register access
	input wire logic [7:0]           sfr_addr,
	input wire logic                 sfr_wr,
	input wire logic                 sfr_rd,
	input wire acc_pkg::acc_byte_t   sfr_rdata,
	input wire logic                 bit_wr,
	input wire logic                 int_ack,
	// dma and strobe
	input wire acc_pkg::acc_chan_t   dma_chan_id,
	input wire logic                 dma_block_done,
	input wire logic                 dma_active,
	input wire logic                 ale_out,
	// converter and results
	input wire logic                 conv_start,
	input wire acc_pkg::acc_chan_t   conv_channel,
	input wire logic                 conv_done,
	input wire acc_pkg::acc_result_t conv_result,
	input wire acc_pkg::acc_byte_t   result_high_byte,
	input wire acc_pkg::acc_byte_t   result_low_byte,
	input wire logic                 conversion_done_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// converter in flight: answers outside this window are ignored
	logic busy_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
		end else if (conv_start) begin
			busy_q <= 1'b1;
		end else if (conv_done || (dma_block_done && dma_active)) begin
			busy_q <= 1'b0;
		end
	end
	a_flag_cause: assert property ($rose(conversion_done_flag) |->
		$past(conv_done) || $past(dma_block_done) || $past(sfr_wr) || $past(bit_wr))
		else $error("flag rose without a cause");
	a_ack_clears: assert property (int_ack && !conv_done && !dma_block_done
		&& !sfr_wr && !bit_wr |=> !conversion_done_flag)
		else $error("flag kept after vector acknowledge");
	a_result_bytes: assert property (busy_q && conv_done &&
		!(dma_block_done && dma_active) |=>
		result_low_byte == $past(conv_result[7:0]) &&
		result_high_byte == {$past(conv_channel), $past(conv_result[11:8])})
		else $error("result bytes wrong");
	a_ale_off: assert property (dma_active |-> !ale_out)
		else $error("strobe toggles during dma");
	a_dma_end: assert property (busy_q && dma_block_done && dma_active
		&& !sfr_wr
		&& !bit_wr |=> !dma_active && conversion_done_flag)
		else $error("dma block end not taken");
	a_start_pulse: assert property (conv_start |=> !conv_start [*2])
		else $error("start pulse too long or too close");
	a_read_zero: assert property (!(sfr_rd && sfr_addr == 8'hd8) |=>
		sfr_rdata == 8'h00)
		else $error("read data not zero");
	a_dma_chan: assert property (conv_start && dma_active |->
		conv_channel == $past(dma_chan_id))
		else $error("dma channel not taken from memory id");
endmodule
bind acc_ctrl acc_ctrl_properties chk_u (.clk(clk), .rst_b(rst_b),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .bit_wr(bit_wr), .int_ack(int_ack),
	.dma_chan_id(dma_chan_id), .dma_block_done(dma_block_done),
	.dma_active(dma_active), .ale_out(ale_out), .conv_start(conv_start),
	.conv_channel(conv_channel), .conv_done(conv_done),
	.conv_result(conv_result), .result_high_byte(result_high_byte),
	.result_low_byte(result_low_byte),
	.conversion_done_flag(conversion_done_flag));
`default_nettype wire

// ==== tb/acc_conv_model.sv ====
// behavioural analog converter answering start pulses
`timescale 1ns/1ps
`default_nettype none
module acc_conv_model #(parameter int LAT = 4) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 conv_start,
	input  wire acc_pkg::acc_chan_t   conv_channel,
	output logic                      conv_done,
	output acc_pkg::acc_result_t      conv_result
);
	int unsigned          cnt;
	acc_pkg::acc_result_t last;
	// result outside the done pulse is not the last value
	assign conv_result = conv_done ? last : ~last;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
			conv_done <= 1'b0;
			last <= '0;
		end else begin
			conv_done <= 1'b0;
			if (conv_start) cnt <= LAT;
			else if (cnt == 1) begin
				conv_done <= 1'b1;
				last <= {conv_channel, ~conv_channel, conv_channel};
				cnt <= 0;
			end else if (cnt > 1) cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// ==== tb/adc_conversion_control_bench.sv ====
// self-checking bench for the conversion control register
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_bench;
	import acc_pkg::*;
	logic clk, rst_b, sfr_wr, sfr_rd, bit_wr, bit_wdata, int_ack;
	logic timer_trigger_enable, external_trigger_enable, timer2_overflow;
	logic external_convert_pin_b, dma_block_done, dma_active, ale_in;
	logic ale_out, conv_start, conv_done, conversion_done_flag, ale_seen;
	logic [7:0] sfr_addr, bit_addr;
	acc_byte_t sfr_wdata, sfr_rdata, result_high_byte, result_low_byte;
	acc_chan_t dma_chan_id, conv_channel;
	acc_result_t conv_result;
	int n_mismatch, comparisons, n_start;
	logic [23:0] rows [4] = '{24'h1000f0, 24'h1555a5, 24'h1fff0f, 24'h1aaa5a};
	acc_ctrl dut_u (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
		.bit_wdata(bit_wdata), .int_ack(int_ack),
		.timer_trigger_enable(timer_trigger_enable),
		.external_trigger_enable(external_trigger_enable),
		.timer2_overflow(timer2_overflow),
		.external_convert_pin_b(external_convert_pin_b),
		.dma_chan_id(dma_chan_id), .dma_block_done(dma_block_done),
		.dma_active(dma_active), .ale_in(ale_in), .ale_out(ale_out),
		.conv_start(conv_start), .conv_channel(conv_channel),
		.conv_done(conv_done), .conv_result(conv_result),
		.result_high_byte(result_high_byte),
		.result_low_byte(result_low_byte),
		.conversion_done_flag(conversion_done_flag));
	acc_conv_model #(.LAT(4)) conv_u (.clk(clk), .rst_b(rst_b),
		.conv_start(conv_start), .conv_channel(conv_channel),
		.conv_done(conv_done), .conv_result(conv_result));
	// ========================================
	// helpers
	task tick; @(posedge clk); #1; endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a; sfr_wdata = d; sfr_wr = 1; tick; sfr_wr = 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		sfr_addr = a; sfr_rd = 1; tick; sfr_rd = 0; chk("rdata", e, sfr_rdata);
		tick;
	endtask
	task bw(input logic [7:0] a, input logic v);
		bit_addr = a; bit_wdata = v; bit_wr = 1; tick; bit_wr = 0;
	endtask
	task wait_flag;
		for (int k = 0; k < 200 && conversion_done_flag !== 1; k++) tick;
	endtask
	task wait_start;
		tick;
		for (int k = 0; k < 50 && conv_start !== 1; k++) tick;
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ========================================
	// clock, strobe, watchdog
	initial begin clk = 0; forever #25 clk = ~clk; end
	always @(posedge clk) #1 ale_in = ~ale_in;
	always @(posedge clk) if (conv_start === 1) n_start++;
	initial begin #(50 * 20000); n_mismatch++; close_out; end
	// ========================================
	// sequence
	initial begin
		{sfr_wr, sfr_rd, bit_wr, bit_wdata, int_ack, ale_in} = '0;
		{timer_trigger_enable, external_trigger_enable} = '0;
		{timer2_overflow, dma_block_done} = '0;
		external_convert_pin_b = 1; sfr_addr = 0; bit_addr = 0;
		sfr_wdata = 0; dma_chan_id = 0; n_mismatch = 0; comparisons = 0;
		rst_b = 0; repeat (20) @(posedge clk); #1 rst_b = 1;
		rd(8'hd8, 8'h00);
		rd(8'hd9, 8'h00);
		foreach (rows[i]) begin
			wr(8'hd8, rows[i][23:16]);
			wait_flag;
			chk("hi", rows[i][15:8], result_high_byte);
			chk("lo", rows[i][7:0], result_low_byte);
			rd(8'hd8, {4'h8, rows[i][19:16]});
			bw(8'hdf, 1'b0);
			chk("flag", 8'h00, {7'h0, conversion_done_flag});
		end
		$display("single rows done");
		bw(8'hd9, 1'b0); rd(8'hd8, 8'h08);
		bw(8'hd9, 1'b1); rd(8'hd8, 8'h0a);
		wr(8'hd8, 8'h12); wait_flag;
		int_ack = 1; tick; int_ack = 0;
		chk("ack", 8'h00, {7'h0, conversion_done_flag});
		// software clear lands on the very edge that takes conv_done
		wr(8'hd8, 8'h10); repeat (6) tick; bw(8'hdf, 1'b0);
		chk("set", 8'h01, {7'h0, conversion_done_flag});
		$display("bit and ack done");
		n_start = 0; wr(8'hd8, 8'h27); repeat (40) tick;
		wr(8'hd8, 8'h00); repeat (10) tick;
		chk("cont", 8'h01, {7'h0, n_start > 3});
		chk("chan", 8'h07, {4'h0, conv_channel});
		wr(8'hd8, 8'h00);
		$display("continuous done");
		dma_chan_id = 4'h9; wr(8'hd8, 8'h40); wait_start; wait_start; tick;
		chk("dmach", 8'h09, {4'h0, conv_channel});
		chk("ale", 8'h00, {7'h0, ale_out});
		dma_block_done = 1; tick; dma_block_done = 0;
		chk("dma", 8'h01, {6'h0, dma_active, conversion_done_flag});
		repeat (10) tick; ale_seen = ale_out; tick;
		chk("ale", 8'h01, {7'h0, ale_seen ^ ale_out});
		wr(8'hd8, 8'h00);
		$display("dma done");
		timer_trigger_enable = 1; timer2_overflow = 1; tick; timer2_overflow = 0;
		wait_flag; chk("timer", 8'h01, {7'h0, conversion_done_flag});
		wr(8'hd8, 8'h00); timer_trigger_enable = 0;
		external_trigger_enable = 1; external_convert_pin_b = 0; tick; tick;
		external_convert_pin_b = 1;
		wait_flag; chk("pin", 8'h01, {7'h0, conversion_done_flag});
		$display("triggers done");
		wr(8'hd8, 8'h27); repeat (3) tick; rst_b = 0; tick; tick; rst_b = 1;
		rd(8'hd8, 8'h00); n_start = 0; repeat (10) tick;
		chk("rst", 8'h00, n_start[7:0] | {4'h0, conv_channel});
		$display("reset done");
		close_out;
	end
endmodule
`default_nettype wire
